//--- src/dosc_device.sv
`timescale 1ns/10ps
module dosc_device
    import dosc_pkg::*;
(
    // Clock and power-on reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Serial link from the host
    dosc_if.device link,
    // Analog stage controls
    output logic o_core_float_select,
    output logic o_output_ground_clamp,
    output logic o_feedback_resistor_select,
    output logic o_feedback_parallel,
    output logic o_gain_pair_enable,
    output logic [3:0] o_lin_comp,
    output dosc_out_state_t o_out_state,
    output logic o_drive_negative_reference_level
);
    logic [2:0] pins;
    logic sclk_prev, sync_n_prev;
    logic [FRAME_BITS-1:0] shift, next_shift;
    logic [4:0] count, next_count;
    logic data_loaded, next_data_loaded;
    logic next_float, next_clamp, next_rsel;
    logic [3:0] next_comp;
    dosc_out_state_t next_state;
    logic frame_done, frame_ok;

    // Idle pin levels: frame select high, serial clock high, data low
    dosc_sync #(.W(3), .INIT(3'h6)) u_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async({link.sync_n, link.sclk, link.sdin}),
        .o_sync(pins)
    );

    // ------------------------------------------------------------
    // Frame capture: data is taken on the falling serial clock
    // ------------------------------------------------------------
    assign frame_done = pins[2] && !sync_n_prev;
    // Short or long frames are dropped whole, writes only
    assign frame_ok = frame_done && (count == 5'(FRAME_BITS)) && !shift[RW_POS]; // R11

    always_comb begin
        next_shift = shift;
        next_count = count;
        if (pins[2]) begin
            next_count = 5'h0;
        end else if (sclk_prev && !pins[1]) begin
            next_shift = {shift[FRAME_BITS-2:0], pins[0]};
            if (count != 5'h1f) begin
                next_count = count + 5'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Register update and output decode
    // ------------------------------------------------------------
    always_comb begin
        next_float = o_core_float_select;
        next_clamp = o_output_ground_clamp;
        next_rsel = o_feedback_resistor_select;
        next_comp = o_lin_comp;
        next_data_loaded = data_loaded;
        if (frame_ok) begin
            case (shift[ADDR_MSB:ADDR_LSB])
                ADDR_CTRL: begin
                    next_float = shift[FLOAT_POS]; // R03
                    next_clamp = shift[CLAMP_POS]; // R03
                    next_rsel = shift[RSEL_POS]; // R09 R10
                    next_comp = shift[COMP_MSB:COMP_LSB];
                end
                ADDR_DATA: begin
                    next_data_loaded = 1'b1;
                end
                ADDR_SWCTRL: begin
                    // Software reset returns to the power-on state
                    if (shift[SWRESET_POS]) begin
                        next_float = FLOAT_RESET; // R02
                        next_clamp = CLAMP_RESET; // R02
                        next_rsel = RSEL_RESET;
                        next_comp = COMP_RESET; // R08
                        next_data_loaded = 1'b0;
                    end
                end
                default: begin
                    next_data_loaded = data_loaded;
                end
            endcase
        end
        if (next_clamp) begin
            next_state = DOSC_OUT_CLAMP; // R06
        end else if (next_float) begin
            next_state = DOSC_OUT_FLOAT; // R06
        end else begin
            next_state = DOSC_OUT_NORMAL; // R06
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sclk_prev <= 1'b1;
            sync_n_prev <= 1'b1;
            shift <= '0;
            count <= 5'h0;
            data_loaded <= 1'b0;
            o_core_float_select <= FLOAT_RESET; // R01 R02
            o_output_ground_clamp <= CLAMP_RESET; // R01 R02
            o_feedback_resistor_select <= RSEL_RESET;
            o_feedback_parallel <= RSEL_RESET;
            o_gain_pair_enable <= !RSEL_RESET;
            o_lin_comp <= COMP_RESET; // R08
            o_out_state <= DOSC_OUT_CLAMP;
            o_drive_negative_reference_level <= 1'b0;
        end else begin
            sclk_prev <= pins[1];
            sync_n_prev <= pins[2];
            shift <= next_shift;
            count <= next_count;
            data_loaded <= next_data_loaded;
            o_core_float_select <= next_float;
            o_output_ground_clamp <= next_clamp;
            o_feedback_resistor_select <= next_rsel;
            o_feedback_parallel <= next_rsel; // R09
            o_gain_pair_enable <= !next_rsel; // R10
            o_lin_comp <= next_comp;
            o_out_state <= next_state;
            // Default data code maps to the negative reference
            o_drive_negative_reference_level <= (next_state == DOSC_OUT_NORMAL) && !next_data_loaded; // R05
        end
    end
endmodule

//--- src/dosc_pkg.sv
// Behaviour
// (R01) Power-on resets every register to default
// (R02) Start tristated, output clamped to ground
// (R03) Hold that state until control write
// (R04) Host clears tristate and clamp bits first
// (R05) Normal without data write drives negative reference
// (R06) Clamp wins; tristate alone floats; both clear normal
// (R07) Host sets compensation 0000 or 1100
// (R08) Compensation field resets to zero
// (R09) Resistor select 1 parallels feedback resistors
// (R10) Resistor select 0 presents matched pair
// (R11) Apply bits only on complete valid frame
package dosc_pkg;
    // ------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 24;
    localparam int RW_POS = 23;
    localparam int ADDR_MSB = 22;
    localparam int ADDR_LSB = 20;
    localparam logic [2:0] ADDR_DATA = 3'h1;
    localparam logic [2:0] ADDR_CTRL = 3'h2;
    localparam logic [2:0] ADDR_SWCTRL = 3'h4;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int RSEL_POS = 1;
    localparam int CLAMP_POS = 2;
    localparam int FLOAT_POS = 3;
    localparam int COMP_LSB = 6;
    localparam int COMP_MSB = 9;
    localparam int SWRESET_POS = 2;
    localparam logic RSEL_RESET = 1'h0;
    localparam logic CLAMP_RESET = 1'h1;
    localparam logic FLOAT_RESET = 1'h1;
    localparam logic [3:0] COMP_RESET = 4'h0;
    localparam logic [3:0] COMP_10V = 4'h0;
    localparam logic [3:0] COMP_20V = 4'hc;
    // ------------------------------------------------------------
    // Host register map (Avalon word index) and timing
    // ------------------------------------------------------------
    localparam logic [1:0] HREG_FRAME = 2'h0;
    localparam logic [1:0] HREG_STATUS = 2'h1;
    localparam int CLOCK_MHZ = 50;
    localparam int SCLK_HALF_NS = 80;
    localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS * CLOCK_MHZ + 999) / 1000;
    localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYCLES - 1);

    typedef enum logic [1:0] {
        DOSC_OUT_NORMAL = 2'b00,
        DOSC_OUT_CLAMP = 2'b01,
        DOSC_OUT_FLOAT = 2'b10
    } dosc_out_state_t;

    typedef enum logic [1:0] {
        DOSC_H_IDLE = 2'b00,
        DOSC_H_LOW = 2'b01,
        DOSC_H_HIGH = 2'b10,
        DOSC_H_END = 2'b11
    } dosc_host_state_t;
endpackage

//--- src/dosc_if.sv
`timescale 1ns/10ps
interface dosc_if;
    logic sclk;
    logic sync_n;
    logic sdin;
    modport host (output sclk, output sync_n, output sdin);
    modport device (input sclk, input sync_n, input sdin);
endinterface

//--- src/dosc_sync.sv
`timescale 1ns/10ps
module dosc_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Pins and filtered levels
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] s1, s2, s3, next_out;

    // A bit only changes once the second and third stages agree
    always_comb begin
        next_out = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & o_sync);
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            o_sync <= INIT;
        end else begin
            s1 <= i_async;
            s2 <= s1;
            s3 <= s2;
            o_sync <= next_out;
        end
    end
endmodule

//--- src/dosc_host.sv
`timescale 1ns/10ps
module dosc_host
    import dosc_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Avalon-MM slave
    input wire logic [1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Serial link to the converter
    dosc_if.host link
);
    dosc_host_state_t state, next_state;
    logic [FRAME_BITS-1:0] shift, next_shift;
    logic [4:0] bits, next_bits;
    logic [3:0] tick, next_tick;
    logic next_sclk, next_sync_n, next_sdin;
    logic [31:0] next_readdata;
    logic next_wait;
    logic wr_go;

    // ------------------------------------------------------------
    // Bus slave: one wait cycle on every access
    // ------------------------------------------------------------
    assign wr_go = i_avs_write && !o_avs_waitrequest && (i_avs_address == HREG_FRAME) && (state == DOSC_H_IDLE);

    always_comb begin
        next_wait = 1'b1;
        next_readdata = o_avs_readdata;
        if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
            next_wait = 1'b0;
            if (i_avs_read) begin
                case (i_avs_address)
                    HREG_FRAME: next_readdata = {8'h0, shift};
                    HREG_STATUS: next_readdata = {31'h0, state != DOSC_H_IDLE};
                    default: next_readdata = 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Serial engine; a frame written while busy is dropped
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_shift = shift;
        next_bits = bits;
        next_tick = (tick == HALF_LAST) ? 4'h0 : tick + 4'h1;
        next_sclk = link.sclk;
        next_sync_n = link.sync_n;
        next_sdin = link.sdin;
        case (state)
            DOSC_H_IDLE: begin
                next_tick = 4'h0;
                if (wr_go) begin
                    // Software orders such as clearing float and clamp go out here
                    next_shift = i_avs_writedata[FRAME_BITS-1:0]; // R04 R07 R09 R10
                    next_bits = 5'h0;
                    next_sync_n = 1'b0;
                    next_sdin = i_avs_writedata[FRAME_BITS-1];
                    next_state = DOSC_H_HIGH;
                end
            end
            DOSC_H_HIGH: begin
                if (tick == HALF_LAST) begin
                    next_sclk = 1'b0;
                    next_bits = bits + 5'h1;
                    next_state = DOSC_H_LOW;
                end
            end
            DOSC_H_LOW: begin
                if (tick == HALF_LAST) begin
                    next_sclk = 1'b1;
                    if (bits == 5'(FRAME_BITS)) begin
                        next_state = DOSC_H_END;
                    end else begin
                        next_shift = {shift[FRAME_BITS-2:0], shift[FRAME_BITS-1]};
                        next_sdin = shift[FRAME_BITS-2];
                        next_state = DOSC_H_HIGH;
                    end
                end
            end
            DOSC_H_END: begin
                next_sync_n = 1'b1;
                if (tick == HALF_LAST) begin
                    next_state = DOSC_H_IDLE;
                end
            end
            default: begin
                next_state = DOSC_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state <= DOSC_H_IDLE;
            shift <= '0;
            bits <= 5'h0;
            tick <= 4'h0;
            link.sclk <= 1'b1;
            link.sync_n <= 1'b1;
            link.sdin <= 1'b0;
            o_avs_readdata <= 32'h0;
            o_avs_waitrequest <= 1'b1;
        end else begin
            state <= next_state;
            shift <= next_shift;
            bits <= next_bits;
            tick <= next_tick;
            link.sclk <= next_sclk;
            link.sync_n <= next_sync_n;
            link.sdin <= next_sdin;
            o_avs_readdata <= next_readdata;
            o_avs_waitrequest <= next_wait;
        end
    end
endmodule

//--- sim/dosc_checker.sv
`timescale 1ns/10ps
module dosc_checker
    import dosc_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Link and bus answer
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic o_avs_waitrequest,
    // Device outputs
    input wire logic o_core_float_select,
    input wire logic o_output_ground_clamp,
    input wire logic o_feedback_resistor_select,
    input wire logic o_feedback_parallel,
    input wire logic o_gain_pair_enable,
    input wire logic [3:0] o_lin_comp,
    input wire dosc_out_state_t o_out_state,
    input wire logic o_drive_negative_reference_level
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // ------------------------------------------------------------
    // Cycles since the frame select was released
    // ------------------------------------------------------------
    logic [4:0] since;
    logic [4:0] next_since;
    always_comb begin
        next_since = since;
        if (!sync_n) begin
            next_since = 5'h0;
        end else if (since != 5'h1f) begin
            next_since = since + 5'h1;
        end
    end
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            since <= 5'h1f;
        end else begin
            since <= next_since;
        end
    end
    sequence por_release;
        $fell(i_rst);
    endsequence
    sequence bus_ack;
        !o_avs_waitrequest;
    endsequence
    chk_por_defaults: assert property (por_release |-> o_core_float_select && o_output_ground_clamp
        && o_lin_comp == 4'h0 && o_out_state == DOSC_OUT_CLAMP && !o_feedback_resistor_select)
        else $error("defaults wrong after power-on");
    chk_state_decode: assert property (o_out_state == (o_output_ground_clamp ? DOSC_OUT_CLAMP :
        (o_core_float_select ? DOSC_OUT_FLOAT : DOSC_OUT_NORMAL))) else $error("output state decode wrong");
    chk_parallel_sel: assert property (o_feedback_parallel == o_feedback_resistor_select)
        else $error("parallel feedback mismatch");
    chk_gain_pair: assert property (o_gain_pair_enable == !o_feedback_resistor_select)
        else $error("gain pair mismatch");
    chk_state_hold: assert property ($changed({o_core_float_select, o_output_ground_clamp}) |-> sync_n && since < 5'h10)
        else $error("output state changed outside a frame end");
    chk_config_apply: assert property ($changed({o_lin_comp, o_feedback_resistor_select}) |-> sync_n && since < 5'h10)
        else $error("configuration changed outside a frame end");
    chk_neg_ref: assert property (o_drive_negative_reference_level |-> o_out_state == DOSC_OUT_NORMAL)
        else $error("negative level outside normal state");
    chk_ack_pulse: assert property (bus_ack |=> o_avs_waitrequest) else $error("waitrequest low too long");
    chk_link_idle: assert property (sync_n && $past(sync_n) |-> sclk) else $error("serial clock not idle high");
endmodule

//--- sim/test_dac_output_state_control.sv
`timescale 1ns/10ps
module test_dac_output_state_control;
    import dosc_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [1:0] av_addr = 2'h0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wd = 32'h0;
    logic [31:0] av_rdata;
    logic [31:0] q;
    logic av_wait;
    logic fl, cl, rs, par, gp, neg;
    logic [3:0] lin;
    dosc_out_state_t st;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    dosc_if link();
    always #10 i_clock = ~i_clock;
    dosc_host dosc_host_i (.i_clock(i_clock), .i_rst(i_rst), .i_avs_address(av_addr), .i_avs_read(av_rd),
        .i_avs_write(av_wr), .i_avs_writedata(av_wd), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
        .link(link));
    dosc_device dosc_device_i (.i_clock(i_clock), .i_rst(i_rst), .link(link), .o_core_float_select(fl),
        .o_output_ground_clamp(cl), .o_feedback_resistor_select(rs), .o_feedback_parallel(par),
        .o_gain_pair_enable(gp), .o_lin_comp(lin), .o_out_state(st), .o_drive_negative_reference_level(neg));
    dosc_checker dosc_checker_i (.i_clock(i_clock), .i_rst(i_rst), .sclk(link.sclk), .sync_n(link.sync_n),
        .o_avs_waitrequest(av_wait), .o_core_float_select(fl), .o_output_ground_clamp(cl),
        .o_feedback_resistor_select(rs), .o_feedback_parallel(par), .o_gain_pair_enable(gp),
        .o_lin_comp(lin), .o_out_state(st), .o_drive_negative_reference_level(neg));
    // ------------------------------------------------------------
    // Bus and frame helpers
    // ------------------------------------------------------------
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task av(input logic wr, input logic [1:0] a, input logic [31:0] d);
        @(posedge i_clock);
        av_addr <= a;
        av_wr <= wr;
        av_rd <= !wr;
        av_wd <= d;
        do @(posedge i_clock); while (av_wait !== 1'b0);
        q = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask
    // Busy is checked right after every frame is handed over
    task send(input logic [2:0] a, input logic [19:0] d, input logic rw);
        av(1'b1, HREG_FRAME, {8'h0, rw, a, d});
        av(1'b0, HREG_STATUS, 32'h0);
        chk(32'(q[0]), 32'h1, "busy after frame");
        while (q[0] !== 1'b0) av(1'b0, HREG_STATUS, 32'h0);
        repeat (12) @(posedge i_clock);
    endtask
    function automatic logic [19:0] ctl(logic f, logic c, logic r, logic [3:0] lc);
        return 20'({lc, 2'b00, f, c, r, 1'b0});
    endfunction
    task dev(input logic f, c, input dosc_out_state_t s, input logic [3:0] lc, input logic r, n);
        chk(32'({fl, cl, st, lin, rs, par, gp, neg}), 32'({f, c, s, lc, r, r, !r, n}), "device outputs");
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_hold;
        dev(1'b1, 1'b1, DOSC_OUT_CLAMP, 4'h0, 1'b0, 1'b0);
        send(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1, 4'hc), 1'b1);
        send(3'h3, 20'h0, 1'b0);
        dev(1'b1, 1'b1, DOSC_OUT_CLAMP, 4'h0, 1'b0, 1'b0);
        av(1'b0, 2'h2, 32'h0);
        chk(q, 32'h0, "unmapped read");
        $display("test hold done");
    endtask
    task t_decode;
        logic [1:0] i;
        dosc_out_state_t s;
        for (int k = 3; k >= 0; k--) begin
            i = 2'(k);
            s = i[0] ? DOSC_OUT_CLAMP : (i[1] ? DOSC_OUT_FLOAT : DOSC_OUT_NORMAL);
            send(ADDR_CTRL, ctl(i[1], i[0], 1'b0, 4'h0), 1'b0);
            dev(i[1], i[0], s, 4'h0, 1'b0, k == 0);
        end
        send(ADDR_DATA, 20'h12345, 1'b0);
        dev(1'b0, 1'b0, DOSC_OUT_NORMAL, 4'h0, 1'b0, 1'b0);
        $display("test decode done");
    endtask
    task t_config;
        send(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1, COMP_20V), 1'b0);
        dev(1'b0, 1'b0, DOSC_OUT_NORMAL, COMP_20V, 1'b1, 1'b0);
        send(ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0, COMP_10V), 1'b0);
        dev(1'b1, 1'b0, DOSC_OUT_FLOAT, COMP_10V, 1'b0, 1'b0);
        send(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1, COMP_20V), 1'b0);
        $display("test config done");
    endtask
    task t_soft_reset;
        // Other software control bits leave the configuration alone
        send(ADDR_SWCTRL, 20'h3, 1'b0);
        dev(1'b0, 1'b0, DOSC_OUT_NORMAL, COMP_20V, 1'b1, 1'b0);
        send(ADDR_SWCTRL, 20'h4, 1'b0);
        dev(1'b1, 1'b1, DOSC_OUT_CLAMP, COMP_RESET, 1'b0, 1'b0);
        send(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b0, 4'h0), 1'b0);
        dev(1'b0, 1'b0, DOSC_OUT_NORMAL, 4'h0, 1'b0, 1'b1);
        // The second frame lands while the first is on the wire and is dropped
        av(1'b1, HREG_FRAME, {8'h0, 1'b0, ADDR_CTRL, ctl(1'b0, 1'b1, 1'b0, 4'h0)});
        av(1'b1, HREG_FRAME, {8'h0, 1'b0, ADDR_CTRL, ctl(1'b1, 1'b0, 1'b1, COMP_20V)});
        q = 32'h1;
        while (q[0] !== 1'b0) av(1'b0, HREG_STATUS, 32'h0);
        repeat (12) @(posedge i_clock);
        dev(1'b0, 1'b1, DOSC_OUT_CLAMP, 4'h0, 1'b0, 1'b0);
        $display("test soft reset done");
    endtask
    task t_power_on;
        send(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1, COMP_20V), 1'b0);
        send(ADDR_DATA, 20'h1, 1'b0);
        dev(1'b0, 1'b0, DOSC_OUT_NORMAL, COMP_20V, 1'b1, 1'b0);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        dev(1'b1, 1'b1, DOSC_OUT_CLAMP, COMP_RESET, 1'b0, 1'b0);
        send(ADDR_CTRL, ctl(1'b0, 1'b0, 1'b0, COMP_10V), 1'b0);
        dev(1'b0, 1'b0, DOSC_OUT_NORMAL, COMP_10V, 1'b0, 1'b1);
        $display("test power-on done");
    endtask
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        t_hold();
        t_decode();
        t_config();
        t_soft_reset();
        t_power_on();
        give_verdict();
    end
endmodule
